// File: bench/pfrc_core_bench.sv
/* pfrc_core_bench: scenario bench for pfrc_core beside the partner model.
   assumes: shortened check and undervoltage counts, one 100 MHz clock. */
`timescale 1ns/1ns
`default_nettype none
module pfrc_core_bench
    import pfrc_pkg::*;
;
    localparam int CK = 64;          // short check interval
    localparam int W = 2 * CK + 48;  // worst wait for a verdict
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic hot = 1'b0, opn = 1'b0, shrt = 1'b0; // thermistor comparators
    logic cuv = 1'b0, uvf = 1'b0, ov = 1'b0;   // cell monitor levels
    logic plug = 1'b0, load = 1'b1;            // partner commands
    logic sense, ext, gone, charging, bias, tline, oe, charge_switch_drive, discharge_switch_drive, regulator_output, bal, irq;
    logic [7:0] rdata;
    pfrc_therm_type th;
    int failures = 0;
    int checks_done = 0;
    assign th = {ext, opn, shrt, hot};
    always #5 clk = ~clk;
    // ------------------------------------------------------------
    // block and far side
    // ------------------------------------------------------------
    pfrc_core #(.UV_LIMIT_CYC(50), .CHECK_CYC(CK), .CHG_SENSE_FITTED(1)) i_dut (
        .clk_i(clk), .sys_rst_i(rst), .clk_en_i(1'b1),
        .charger_sense_input_i(sense), .temperature_sense_input_i(th),
        .all_cells_uv_i(cuv), .uv_fault_i(uvf), .ov_event_i(ov),
        .discharge_return_sense_i(gone), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata),
        .thermistor_bias_supply_o(bias), .therm_line_o(tline), .therm_line_oe_o(oe),
        .charge_switch_drive_o(charge_switch_drive), .discharge_switch_drive_o(discharge_switch_drive),
        .regulator_output_o(regulator_output), .balance_allow_o(bal), .irq_o(irq));
    pfrc_partner i_far (.clk_i(clk), .plug_i(plug), .load_i(load), .line_oe_i(oe),
        .sense_o(sense), .ext_bias_o(ext), .load_gone_o(gone), .charging_o(charging));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // one-cycle write strobe, never overlapping a read
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    // wait, then let the edge's updates land
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        cyc(3);
        chk({regulator_output, charge_switch_drive, discharge_switch_drive}, 8'h07);
        rd(ADDR_CTRL, CTRL_RST);
        wr(ADDR_STAT, 8'hFF);
        rd(ADDR_STAT, 8'h10);      // write ignored, only regulator on
        rd(4'hF, 8'h00);
    endtask
    task automatic t_hot;
        wr(ADDR_IRQ_EN, 8'h01);
        hot <= 1'b1;
        cyc(W);
        chk({regulator_output, charge_switch_drive, discharge_switch_drive, irq}, 8'h09);
        rd(ADDR_IRQ_STAT, 8'h01);
        wr(ADDR_IRQ_EN, 8'h00);
        cyc(1);
        chk(irq, 1'b0);            // masked event keeps irq low
        @(posedge clk);
        hot <= 1'b0;
        cyc(W);
        chk(charge_switch_drive, 1'b1);
        // clear only once no late verdict can set the flag again
        wr(ADDR_IRQ_CLR, 8'h3F);
        rd(ADDR_IRQ_STAT, 8'h00);
    endtask
    // open and hot together: open wins and the regulator stays on
    task automatic t_order;
        @(posedge clk);
        hot <= 1'b1;
        opn <= 1'b1;
        cyc(W);
        chk({regulator_output, charge_switch_drive, discharge_switch_drive}, 8'h04);
        rd(ADDR_IRQ_STAT, 8'h02);
        @(posedge clk);
        hot <= 1'b0;
        opn <= 1'b0;
        cyc(W);
        chk({charge_switch_drive, discharge_switch_drive}, 8'h03);
        wr(ADDR_IRQ_CLR, 8'h3F);
    endtask
    task automatic t_short;
        @(posedge clk);
        shrt <= 1'b1;
        opn <= 1'b1;
        cyc(W);
        chk({regulator_output, charge_switch_drive, discharge_switch_drive}, 8'h00);
        @(posedge clk);
        shrt <= 1'b0;
        opn <= 1'b0;
        cyc(W);
        chk(regulator_output, 1'b0);
        plug <= 1'b1;
        cyc(12);
        chk(regulator_output, 1'b1);
        rd(ADDR_IRQ_STAT, 8'h34);
        wr(ADDR_IRQ_CLR, 8'h3F);
    endtask
    // charger bias on the thermistor keeps the own supply quiet
    task automatic t_bias;
        logic seen;
        cyc(W);
        seen = 1'b0;
        repeat (W) begin
            cyc(1);
            seen = seen | bias;
        end
        chk(seen, 1'b0);
        plug <= 1'b0;
        cyc(W);
        seen = 1'b0;
        repeat (W) begin
            cyc(1);
            seen = seen | bias;
        end
        chk(seen, 1'b1);
    endtask
    task automatic t_uv;
        @(posedge clk);
        cuv <= 1'b1;
        uvf <= 1'b1;
        cyc(100);
        chk(regulator_output, 1'b1);
        wr(ADDR_CTRL, 8'h01);
        cyc(40);
        chk(regulator_output, 1'b1);
        cyc(20);
        chk(regulator_output, 1'b0);
        @(posedge clk);
        cuv <= 1'b0;
        uvf <= 1'b0;
        wr(ADDR_CTRL, 8'h00);
        cyc(20);
        chk(regulator_output, 1'b0);
        plug <= 1'b1;
        cyc(12);
        chk(regulator_output, 1'b1);
    endtask
    task automatic t_ov;
        @(posedge clk);
        ov <= 1'b1;
        cyc(4);
        chk(oe, 1'b0);
        wr(ADDR_CTRL, 8'h02);
        cyc(3);
        chk({oe, tline}, 8'h02);
        cyc(2);
        chk(charging, 1'b0);
        @(posedge clk);
        ov <= 1'b0;
        cyc(3);
        chk(oe, 1'b0);
        wr(ADDR_IRQ_CLR, 8'h3F);
        load <= 1'b0;
        cyc(8);
        rd(ADDR_IRQ_STAT, 8'h08);
        load <= 1'b1;
    endtask
    // balance modes: always, never, charge only with and without charger
    task automatic t_bal;
        wr(ADDR_CTRL, 8'h04);
        cyc(3);
        chk(bal, 1'b1);
        wr(ADDR_CTRL, 8'h00);
        cyc(3);
        chk(bal, 1'b0);
        wr(ADDR_CTRL, 8'h08);
        cyc(3);
        chk(bal, 1'b1);
        plug <= 1'b0;
        cyc(8);
        chk(bal, 1'b0);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_hot();
        t_order();
        t_short();
        t_bias();
        t_uv();
        t_ov();
        t_bal();
        finish_test();
    end
    // about five times the expected run
    initial begin
        #100000;
        failures++;
        finish_test();
    end
endmodule
`default_nettype wire

// File: bench/pfrc_partner.sv
/* pfrc_partner: charger and pack load at the far side of the protector.
   assumes: the bench commands plug and load on clk_i; the charger biases
   the thermistor itself while attached and the protector does not pull the line. */
`timescale 1ns/1ns
`default_nettype none
module pfrc_partner (
    input wire logic clk_i,
    input wire logic plug_i,      // charger attached
    input wire logic load_i,      // load attached
    input wire logic line_oe_i,   // protector pulls the thermistor line
    output logic sense_o,         // charger sense above threshold
    output logic ext_bias_o,      // charger bias lifts the thermistor
    output logic load_gone_o,     // return sense below 2 V
    output logic charging_o       // charger delivers current
);
    // ------------------------------------------------------------
    // charger and load reaction
    // ------------------------------------------------------------
    // a pulled-low line reads as a hot pack: bias drops, charge stops
    always_ff @(posedge clk_i) begin
        sense_o <= plug_i;
        ext_bias_o <= plug_i && !line_oe_i;
        charging_o <= plug_i && !line_oe_i;
        load_gone_o <= !load_i;
    end
endmodule
`default_nettype wire

// File: core/pfrc_core.sv
/*
 * pfrc_core: thermistor checks, shutdown and wake decisions, undervoltage
 * shutdown option, load removal and overvoltage signalling on the thermistor line.
 * assumes: comparator outputs are asynchronous pins; the register port
 * masters are on clk_i.
 */
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module pfrc_core
    import pfrc_pkg::*;
#(
    parameter longint UV_LIMIT_CYC = UV_SHDN_CYC,       // undervoltage shutdown limit
    parameter int CHECK_CYC = THERM_CHECK_CYC,          // thermistor check interval
    parameter int CHG_SENSE_FITTED = 1                  // charger sense pin wired
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,                          // freezes all state when low
    input wire logic charger_sense_input_i,             // sense comparator, above 0.5 V
    input wire pfrc_therm_type temperature_sense_input_i, // thermistor comparators
    input wire logic all_cells_uv_i,                    // all cells below uv plus hysteresis
    input wire logic uv_fault_i,                        // undervoltage fault held elsewhere
    input wire logic ov_event_i,                        // overvoltage event, same clock
    input wire logic discharge_return_sense_i,          // return sense below 2 V
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic thermistor_bias_supply_o,
    output logic therm_line_o,                          // thermline pulled low value
    output logic therm_line_oe_o,                       // high while pulling the line
    output logic charge_switch_drive_o,
    output logic discharge_switch_drive_o,
    output logic regulator_output_o,                    // regulator enable
    output logic balance_allow_o,
    output logic irq_o
);
    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (CHECK_CYC < 2 * BIAS_SETTLE_CYC) begin : g_chk
        $error("check interval too short for bias settling");
    end
    if (UV_LIMIT_CYC < 1 || UV_LIMIT_CYC > 64'h0000_00FF_FFFF_FFFF) begin : g_uvchk
        $error("undervoltage limit must be positive and fit the 40-bit timer");
    end

    // ------------------------------------------------------------
    // pin synchronisers, three stages, agreement of two and three
    // ------------------------------------------------------------
    localparam int NPIN = 6;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
    assign pin_raw = {discharge_return_sense_i, charger_sense_input_i, temperature_sense_input_i};

    // stage one is read only by stage two
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            filt_reg <= '0;
        end else if (clk_en_i) begin
            s1_reg <= pin_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
        end
    end

    pfrc_therm_type th;
    wire charger_det = filt_reg[4];       // always-on monitor
    wire load_gone = filt_reg[5];
    assign th = pfrc_therm_type'(filt_reg[3:0]);

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] ctrl_reg;
    pfrc_evt_type evt_reg, evt_en_reg, evt_set;
    logic [7:0] rdata_reg;
    wire wr_ctrl = wr_i && (addr_i == ADDR_CTRL);
    wire wr_en = wr_i && (addr_i == ADDR_IRQ_EN);
    wire wr_clr = wr_i && (addr_i == ADDR_IRQ_CLR);
    wire uvsd_opt = ctrl_reg[CTRL_UVSD_BIT];
    wire ovts_opt = ctrl_reg[CTRL_OVTS_BIT];
    wire [1:0] bal_mode = ctrl_reg[CTRL_BAL_LSB+1:CTRL_BAL_LSB];

    // control and enable registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl_reg <= CTRL_RST;
            evt_en_reg <= '0;
        end else if (clk_en_i) begin
            if (wr_ctrl) begin
                ctrl_reg <= wdata_i;
            end
            if (wr_en) begin
                evt_en_reg <= pfrc_evt_type'(wdata_i[NUM_EVT-1:0]);
            end
        end
    end

    // sticky status: set beats a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            evt_reg <= '0;
        end else if (clk_en_i) begin
            evt_reg <= (evt_reg & ~(wr_clr ? pfrc_evt_type'(wdata_i[NUM_EVT-1:0]) : '0)) | evt_set;
        end
    end
    assign irq_o = |(evt_reg & evt_en_reg);

    // ------------------------------------------------------------
    // thermistor check sequencer
    // ------------------------------------------------------------
    pfrc_check_type ck_reg, ck_next;
    logic [31:0] tick_reg;
    logic [7:0] settle_reg;
    logic bias_reg;
    pfrc_state_type st_reg, st_next;                    // power state, also gates the bias pulse
    logic ot_reg, open_reg, short_reg;
    wire tick = (tick_reg == 32'(CHECK_CYC - 1));
    wire settled = (settle_reg == 8'(BIAS_SETTLE_CYC - 1));

    // sequencer next state
    always_comb begin
        ck_next = ck_reg;
        case (ck_reg)
            PFRC_CK_IDLE: begin
                if (tick) begin
                    ck_next = PFRC_CK_SENSE;
                end
            end
            PFRC_CK_SENSE: begin
                if (settled) begin
                    // external source seen: keep own bias off
                    ck_next = th.ext_pullup ? PFRC_CK_IDLE : PFRC_CK_BIAS;
                end
            end
            PFRC_CK_BIAS: begin
                if (settled) begin
                    ck_next = PFRC_CK_IDLE;
                end
            end
            default: ck_next = PFRC_CK_IDLE;
        endcase
    end

    // one verdict per check, short first then open then hot
    wire eval = settled && ((ck_reg == PFRC_CK_BIAS) || (ck_reg == PFRC_CK_SENSE && th.ext_pullup));
    wire v_short = th.short_th;
    wire v_open = !th.short_th && th.open_cold;      // cold counts as open
    wire hot_threshold = !th.short_th && !th.open_cold && th.hot;

    // sequencer state, counters and latched verdicts
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ck_reg <= PFRC_CK_IDLE;
            tick_reg <= '0;
            settle_reg <= '0;
            bias_reg <= 1'b0;
            ot_reg <= 1'b0;
            open_reg <= 1'b0;
            short_reg <= 1'b0;
        end else if (clk_en_i) begin
            ck_reg <= ck_next;
            tick_reg <= tick ? '0 : tick_reg + 32'h1;
            settle_reg <= (ck_next != ck_reg) ? '0 : settle_reg + 8'h01;
            bias_reg <= (ck_next == PFRC_CK_BIAS);
            if (eval) begin
                // verdicts replaced each check, so open clears next check
                ot_reg <= hot_threshold;
                open_reg <= v_open;
                short_reg <= v_short;
            end
        end
    end
    // no bias while the regulator is down
    assign thermistor_bias_supply_o = bias_reg && (st_reg != PFRC_ST_SHUTDOWN);

    // ------------------------------------------------------------
    // undervoltage shutdown timer
    // ------------------------------------------------------------
    logic [39:0] uv_cnt_reg;
    wire uv_expired = (uv_cnt_reg == 40'(UV_LIMIT_CYC));

    // counts only while the option is set
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            uv_cnt_reg <= '0;
        end else if (clk_en_i) begin
            if (!uvsd_opt || !all_cells_uv_i || !uv_fault_i) begin
                uv_cnt_reg <= '0;
            end else if (!uv_expired) begin
                uv_cnt_reg <= uv_cnt_reg + 40'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // power state
    // ------------------------------------------------------------
    logic short_new, shdn_req;
    assign short_new = eval && v_short;
    // short without charger shuts down; short under charger only protects
    assign shdn_req = (short_new && !charger_det) || (uvsd_opt && uv_expired);

    // state choice
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            PFRC_ST_AWAKE, PFRC_ST_PROTECT: begin
                if (shdn_req) begin
                    st_next = PFRC_ST_SHUTDOWN;
                end else if (ot_reg || open_reg || short_reg) begin
                    st_next = PFRC_ST_PROTECT;      // hot never shuts down
                end else begin
                    st_next = PFRC_ST_AWAKE;
                end
            end
            PFRC_ST_SHUTDOWN: begin
                if (charger_det) begin
                    st_next = PFRC_ST_AWAKE;        // only way out
                end
            end
            default: st_next = PFRC_ST_AWAKE;
        endcase
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_reg <= PFRC_ST_AWAKE;
        end else if (clk_en_i) begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic reg_on_reg, chg_reg, dsg_reg, tl_reg, bal_reg;
    wire reg_on = (st_next != PFRC_ST_SHUTDOWN);
    wire sw_ok = reg_on && (st_next == PFRC_ST_AWAKE);

    // output flops
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            reg_on_reg <= 1'b1;
            chg_reg <= 1'b0;
            dsg_reg <= 1'b0;
            tl_reg <= 1'b0;
            bal_reg <= 1'b0;
        end else if (clk_en_i) begin
            reg_on_reg <= reg_on;
            chg_reg <= sw_ok;                         // off with regulator
            dsg_reg <= sw_ok && !uv_fault_i;
            tl_reg <= ovts_opt && ov_event_i && reg_on;
            // charge-only needs a fitted sense pin
            case (bal_mode)
                PFRC_BAL_ALWAYS: bal_reg <= reg_on;
                PFRC_BAL_CHARGE: bal_reg <= reg_on && (CHG_SENSE_FITTED != 0) && charger_det;
                default: bal_reg <= 1'b0;
            endcase
        end
    end
    assign regulator_output_o = reg_on_reg;
    assign charge_switch_drive_o = chg_reg;
    assign discharge_switch_drive_o = dsg_reg;
    assign therm_line_o = 1'b0;
    assign therm_line_oe_o = tl_reg;
    assign balance_allow_o = bal_reg;

    // events
    assign evt_set = '{charger: charger_det && (st_reg == PFRC_ST_SHUTDOWN),
                       shutdown: (st_next == PFRC_ST_SHUTDOWN) && (st_reg != PFRC_ST_SHUTDOWN),
                       load_removed: load_gone,
                       short_th: short_new,
                       open_cold: eval && v_open,
                       over_temp: eval && hot_threshold};

    // ------------------------------------------------------------
    // read port, data one cycle after the strobe
    // ------------------------------------------------------------
    wire [7:0] stat_word = {1'b0, load_gone, charger_det, reg_on_reg, short_reg, open_reg, ot_reg, uv_expired};
    wire [7:0] rd_mux = (addr_i == ADDR_CTRL) ? ctrl_reg :
                        (addr_i == ADDR_STAT) ? stat_word :
                        (addr_i == ADDR_IRQ_STAT) ? 8'(evt_reg) :
                        (addr_i == ADDR_IRQ_EN) ? 8'(evt_en_reg) : 8'h00;

    // read data flop
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_reg <= 8'h00;
        end else if (clk_en_i) begin
            rdata_reg <= rd_i ? rd_mux : 8'h00;
        end
    end
    assign rdata_o = rdata_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_reg_off_shdn;
        @(posedge clk_i) disable iff (sys_rst_i)
        clk_en_i && (st_next == PFRC_ST_SHUTDOWN) |=> !regulator_output_o;
    endproperty
    a_reg_off_shdn: assert property (p_reg_off_shdn) else $error("regulator on in shutdown");

    property p_chg_off;
        @(posedge clk_i) disable iff (sys_rst_i)
        !regulator_output_o |-> !charge_switch_drive_o;
    endproperty
    a_chg_off: assert property (p_chg_off) else $error("charge drive on with regulator off");

    property p_exit_charger;
        @(posedge clk_i) disable iff (sys_rst_i)
        (st_reg == PFRC_ST_SHUTDOWN) && (st_next != PFRC_ST_SHUTDOWN) |-> charger_det;
    endproperty
    a_exit_charger: assert property (p_exit_charger) else $error("left shutdown without charger");

    property p_bias_ext;
        @(posedge clk_i) disable iff (sys_rst_i)
        clk_en_i && (ck_reg == PFRC_CK_SENSE) && settled && th.ext_pullup |=> !thermistor_bias_supply_o [*2];
    endproperty
    a_bias_ext: assert property (p_bias_ext) else $error("bias on with external pullup");

    property p_ot_no_shdn;
        @(posedge clk_i) disable iff (sys_rst_i)
        clk_en_i && eval && hot_threshold && !(uvsd_opt && uv_expired) && (st_reg != PFRC_ST_SHUTDOWN)
        |=> (st_reg != PFRC_ST_SHUTDOWN);
    endproperty
    a_ot_no_shdn: assert property (p_ot_no_shdn) else $error("overtemperature caused shutdown");

    property p_uv_opt_clear;
        @(posedge clk_i) disable iff (sys_rst_i)
        clk_en_i && !uvsd_opt |=> uv_cnt_reg == 40'h0;
    endproperty
    a_uv_opt_clear: assert property (p_uv_opt_clear) else $error("uv timer ran with option clear");

    property p_short_shdn;
        @(posedge clk_i) disable iff (sys_rst_i)
        clk_en_i && short_new && !charger_det |=> (st_reg == PFRC_ST_SHUTDOWN) ##1 !regulator_output_o;
    endproperty
    a_short_shdn: assert property (p_short_shdn) else $error("short did not shut down");

    property p_tline;
        @(posedge clk_i) disable iff (sys_rst_i)
        therm_line_oe_o |-> $past(ovts_opt) && $past(ov_event_i);
    endproperty
    a_tline: assert property (p_tline) else $error("thermline driven without option and event");
endmodule
`default_nettype wire

// File: include/pfrc_pkg.sv
/*
 * pfrc_pkg: constants and carrier types for the pack fault and recovery
 * control block.
 * assumes: one 100 MHz clock; comparator results arrive as raw pins.
 */
package pfrc_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 100000000;                    // system clock rate
    localparam int UV_SHDN_LIMIT_S = 8;                   // undervoltage shutdown limit, seconds
    localparam longint UV_SHDN_CYC = longint'(UV_SHDN_LIMIT_S) * longint'(CLK_HZ); // cycles in limit
    localparam int THERM_CHECK_CYC = 4096;                // check interval, cycles (default)
    localparam int BIAS_SETTLE_CYC = 16;                  // bias pulse settle time, cycles
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;              // options, balance mode
    localparam logic [3:0] ADDR_STAT = 4'h1;              // live state, read only
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h2;          // sticky events, read only
    localparam logic [3:0] ADDR_IRQ_EN = 4'h3;            // interrupt enables
    localparam logic [3:0] ADDR_IRQ_CLR = 4'h4;           // write one to clear
    localparam logic [7:0] CTRL_RST = 8'h00;              // control after reset
    localparam int CTRL_UVSD_BIT = 0;                     // undervoltage shutdown option
    localparam int CTRL_OVTS_BIT = 1;                     // overvoltage thermline signal
    localparam int CTRL_BAL_LSB = 2;                      // balance mode, 2 bits
    localparam int NUM_EVT = 6;                           // number of event bits
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PFRC_BAL_NEVER = 2'h0,
        PFRC_BAL_ALWAYS = 2'h1,
        PFRC_BAL_CHARGE = 2'h2
    } pfrc_bal_type;

    typedef enum logic [1:0] {
        PFRC_ST_AWAKE = 2'h0,
        PFRC_ST_PROTECT = 2'h1,
        PFRC_ST_SHUTDOWN = 2'h3
    } pfrc_state_type;

    typedef enum logic [1:0] {
        PFRC_CK_IDLE = 2'h0,
        PFRC_CK_SENSE = 2'h1,
        PFRC_CK_BIAS = 2'h3
    } pfrc_check_type;

    // thermistor comparator results, one pin each
    typedef struct packed {
        logic ext_pullup;     // above external_pullup_threshold
        logic open_cold;      // above open threshold
        logic short_th;       // below short threshold
        logic hot;            // below hot_threshold
    } pfrc_therm_type;

    // sticky events
    typedef struct packed {
        logic charger;
        logic shutdown;
        logic load_removed;
        logic short_th;
        logic open_cold;
        logic over_temp;
    } pfrc_evt_type;
endpackage
